// File: hdl/oscts_pin_edge.sv
// oscillator/time stamp support package plus the pin edge detector.
// assumes pins arrive already muxed and are asynchronous to CLK.
`timescale 1ns/1ps

package oscts_pkg;
  localparam int ADDR_W = 6;
  // register byte offsets
  localparam logic [5:0] REG_CLK_CTRL = 6'h00;
  localparam logic [5:0] REG_LF_TRIM = 6'h04;
  localparam logic [5:0] REG_HF_CTRL = 6'h08;
  localparam logic [5:0] REG_STAMP_CTRL = 6'h0C;
  localparam logic [5:0] REG_STAMP_COUNT = 6'h10;
  localparam logic [5:0] REG_SLOT_DELTA = 6'h14;
  localparam logic [5:0] REG_HF_COUNT = 6'h18;
  localparam logic [5:0] REG_STATUS = 6'h1C;
  localparam logic [5:0] REG_PIN_CFG = 6'h20;
  // clock control fields
  localparam int CC_RATE = 0;
  localparam int CC_FAST_EN = 1;
  localparam int CC_SLOW_EN = 2;
  localparam int CC_SRC_LO = 4;
  localparam int CC_ALT_LO = 8;
  localparam int CC_CAL_EN = 12;
  localparam int CC_RUN = 16;
  // trim fields
  localparam int TR_SLOW_LO = 0;
  localparam int TR_FAST_LO = 16;
  localparam int HF_TRIM_LO = 0;
  localparam int HF_START = 16;
  // stamp control fields
  localparam int ST_ARM = 0;
  localparam int ST_PERSIST = 1;
  localparam int ST_INV = 2;
  localparam int ST_PIN_LO = 4;
  // clock source choices
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_EXT_LF = 2'h1;
  localparam logic [1:0] SRC_EXT_HF = 2'h2;
  localparam logic [1:0] SRC_EXT_ALL = 2'h3;
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int CLK_NS = 40;
  localparam int FAST_LF_HZ = 1000000;
  localparam int SLOW_LF_HZ = 32000;
  localparam logic [9:0] FAST_DIV = 10'(CLK_HZ / FAST_LF_HZ);
  localparam logic [9:0] SLOW_DIV = 10'(CLK_HZ / SLOW_LF_HZ);
  localparam logic [9:0] FAST_TRIM_CTR = 10'h008;
  localparam logic [9:0] SLOW_TRIM_CTR = 10'h010;
  localparam logic [9:0] EXT_DIV_FAST = 10'd32;
  localparam logic [9:0] EXT_DIV_SLOW = 10'd1000;
  localparam logic [7:0] CAL_WIN_FAST = 8'd128;
  localparam logic [7:0] CAL_WIN_SLOW = 8'd4;
  localparam int HF_STAB_NS = 10000;
  localparam logic [8:0] HF_STAB_CYC = 9'((HF_STAB_NS + CLK_NS - 1) / CLK_NS);
  localparam int STAMP_W = 24;
  localparam int HFCNT_W = 16;
  localparam int SLOT_W = 16;
  // hf calibration sequence
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b000,
    CAL_WARM = 3'b001,
    CAL_ALIGN = 3'b010,
    CAL_COUNT = 3'b011,
    CAL_DONE = 3'b100
  } oscts_cal_t;
endpackage

//////////////////////////////////////////////////////////////////////////////

module oscts_pin_edge (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic pin, // raw pin level
  input wire logic invert, // 1 = falling edge counts
  output logic edge_pulse // one-cycle pulse per active edge
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic edge_p;
  } oscts_edge_st_t;

  oscts_edge_st_t s_q, s_d;

  // two-flop synchroniser; only s2 feeds the edge compare
  always_comb begin
    s_d = s_q;
    s_d.s1 = pin;
    s_d.s2 = s_q.s1; // see R23
    s_d.prev = s_q.s2;
    s_d.edge_p = (s_q.s2 ^ invert) & ~(s_q.prev ^ invert); // see R15
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign edge_pulse = s_q.edge_p;

  a_edge_cause: assert property (@(posedge clk) disable iff (!rstn) // see R15
    s_q.edge_p |-> ($past(s_q.s2) ^ $past(invert)) && !($past(s_q.prev) ^ $past(invert)))
    else $error("edge pulse without matching edge");
  a_sync_depth: assert property (@(posedge clk) disable iff (!rstn) // see R23
    s_q.s2 |-> $past(s_q.s1))
    else $error("synchroniser skipped a stage");
endmodule

// File: hdl/oscts_top.sv
// clock source select, lf divider, time stamp and hf calibration control.
// assumes an avalon-mm master with waitrequest, gpio pins asynchronous,
// and WAKE_ACTIVE / SLOTS_ACTIVE / NEXT_SLOT_CYCLES from the slot sequencer.
`timescale 1ns/1ps

// Notes on behaviour
// R1: rate select 0 picks the 32 kHz base, 1 picks 1 MHz.
// R2: each internal lf oscillator ticks only while its own enable is 1.
// R3: 6-bit trim field adjusts the 32 kHz oscillator period.
// R4: 10-bit trim field adjusts the 1 MHz oscillator period.
// R5: source field: 0 internal, 1 ext lf, 2 ext hf, 3 both from ext 32 MHz.
// R6: source 3 divides the external clock by 32 or 1000 per rate select.
// R7: external clocks enter only on a pin configured as input and selected.
// R8: internal hf powers only during wake-up, active time slots or hf calibration.
// R9: hf tick drives the fast sequencer, lf tick the slow one.
// R10: external 32 MHz source must run continuously while operating.
// R11: armed capture stamps on the next active edge of the chosen pin.
// R12: arm bit clears after each capture unless persist is set.
// R13: lf cycle count between two captured triggers is readable.
// R14: capture also latches lf cycles to next slot start, valid in go.
// R15: trigger is rising edge by default, falling edge when inverted.
// R16: calibration logic is frozen until calibration clock enable is 1.
// R17: stamp counting needs only the lf oscillator, any run mode.
// R18: hf cal start powers hf, waits stable, counts over 128 or 4 lf.
// R19: final count is loaded, then the start bit clears.
// R20: after calibration hf powers down unless slots are active.
// R21: the lf time base, internal or external, is the calibration window reference.
// R22: host trims lf from stamp counts first, then hf from its count.
// R23: stamp pin passes a two-stage synchroniser before edge detection.
module oscts_top
  import oscts_pkg::*;
(
  input wire logic CLK, // 25 MHz system clock
  input wire logic RSTN, // async reset, active low
  input wire logic [5:0] AVS_ADDRESS, // byte address
  input wire logic AVS_READ, // read request
  input wire logic AVS_WRITE, // write request
  input wire logic [31:0] AVS_WRITEDATA, // write data
  input wire logic [3:0] AVS_BYTEENABLE, // byte lanes
  output logic [31:0] AVS_READDATA, // read data
  output logic AVS_WAITREQUEST, // stall
  input wire logic [3:0] GPIO_IN, // gpio pin levels
  input wire logic WAKE_ACTIVE, // slow sequencer in wake-up
  input wire logic SLOTS_ACTIVE, // time slots running
  input wire logic [15:0] NEXT_SLOT_CYCLES, // lf cycles to next slot
  output logic LF_TICK, // lf time base pulse
  output logic HF_TICK, // hf time base pulse
  output logic FAST_LF_OSC_ON, // 1 MHz oscillator enable
  output logic SLOW_LF_OSC_ON, // 32 kHz oscillator enable
  output logic [5:0] SLOW_LF_TRIM, // 32 kHz trim
  output logic [9:0] FAST_LF_TRIM, // 1 MHz trim
  output logic [9:0] HF_TRIM, // 32 MHz trim
  output logic HF_OSC_POWER, // internal hf power
  output logic [3:0] PIN_INPUT_EN, // gpio input enables
  output logic RUN_MODE // 1 = go, 0 = standby
);
  typedef struct packed {
    logic lf_rate_select;
    logic fast_lf_osc_enable;
    logic slow_lf_osc_enable;
    logic [1:0] clock_source_select;
    logic [1:0] alternate_clock_pin_select;
    logic calibration_clock_enable;
    logic run_mode_select;
    logic [3:0] pin_direction_config;
    logic [5:0] slow_lf_trim;
    logic [9:0] fast_lf_trim;
    logic [9:0] hf_trim;
    logic hf_cal_start;
    logic stamp_capture_arm;
    logic stamp_capture_persist;
    logic stamp_edge_invert;
    logic [1:0] stamp_pin_select;
    logic [STAMP_W-1:0] stamp_interval_count;
    logic [SLOT_W-1:0] cycles_to_next_slot;
    logic [HFCNT_W-1:0] hf_cal_count;
    logic [STAMP_W-1:0] live_cnt;
    logic [9:0] osc_div;
    logic [9:0] ext_div;
    logic lf_tick;
    logic hf_tick;
    logic hf_pwr;
    oscts_cal_t cal_state;
    logic [8:0] stab_cnt;
    logic [7:0] win_cnt;
    logic [HFCNT_W-1:0] hf_run_cnt;
    logic [31:0] rdata;
    logic waitreq;
  } oscts_st_t;

  oscts_st_t s_q, s_d;
  logic alt_edge_raw, stamp_edge_raw;
  logic alt_ok, stamp_ok, alt_edge, stamp_edge;
  logic ext_hf, osc_on, capture, bus_wr, bus_rd_phase;
  logic [9:0] osc_period, ext_div_n;
  logic [7:0] win_target;
  logic [31:0] wmask, rd_mux;

  //////////////////////////////////////////////////////////////////////////
  // pin edge detectors; the mux sits ahead of the synchroniser, so changing
  // a pin select can fake one edge - change selects while idle

  oscts_pin_edge u_alt_edge (
    .clk(CLK),
    .rstn(RSTN),
    .pin(GPIO_IN[s_q.alternate_clock_pin_select]),
    .invert(1'b0),
    .edge_pulse(alt_edge_raw)
  );

  oscts_pin_edge u_stamp_edge (
    .clk(CLK),
    .rstn(RSTN),
    .pin(GPIO_IN[s_q.stamp_pin_select]),
    .invert(s_q.stamp_edge_invert), // see R15
    .edge_pulse(stamp_edge_raw)
  );

  //////////////////////////////////////////////////////////////////////////
  // helper terms
  always_comb begin
    alt_ok = s_q.pin_direction_config[s_q.alternate_clock_pin_select]; // see R7
    alt_edge = alt_edge_raw & alt_ok;
    stamp_ok = s_q.pin_direction_config[s_q.stamp_pin_select];
    stamp_edge = stamp_edge_raw & stamp_ok;
    ext_hf = s_q.clock_source_select[1];
    // each rate only runs off its own enable
    osc_on = s_q.lf_rate_select ? s_q.fast_lf_osc_enable
                                : s_q.slow_lf_osc_enable; // see R2
    // trim shifts the period around its centre value
    osc_period = s_q.lf_rate_select
      ? FAST_DIV + {6'h0, s_q.fast_lf_trim[9:6]} - FAST_TRIM_CTR // see R4
      : SLOW_DIV + {5'h0, s_q.slow_lf_trim[5:1]} - SLOW_TRIM_CTR; // see R3
    ext_div_n = s_q.lf_rate_select ? EXT_DIV_FAST : EXT_DIV_SLOW; // see R6
    win_target = s_q.lf_rate_select ? CAL_WIN_FAST : CAL_WIN_SLOW; // see R18
    capture = s_q.calibration_clock_enable & s_q.stamp_capture_arm & stamp_edge;
    bus_rd_phase = (AVS_READ | AVS_WRITE) & s_q.waitreq;
    bus_wr = AVS_WRITE & ~s_q.waitreq;
    wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
             {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  end

  // read mux; reserved bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS)
      REG_CLK_CTRL: begin
        rd_mux[CC_RATE] = s_q.lf_rate_select;
        rd_mux[CC_FAST_EN] = s_q.fast_lf_osc_enable;
        rd_mux[CC_SLOW_EN] = s_q.slow_lf_osc_enable;
        rd_mux[CC_SRC_LO +: 2] = s_q.clock_source_select;
        rd_mux[CC_ALT_LO +: 2] = s_q.alternate_clock_pin_select;
        rd_mux[CC_CAL_EN] = s_q.calibration_clock_enable;
        rd_mux[CC_RUN] = s_q.run_mode_select;
      end
      REG_LF_TRIM: begin
        rd_mux[TR_SLOW_LO +: 6] = s_q.slow_lf_trim;
        rd_mux[TR_FAST_LO +: 10] = s_q.fast_lf_trim;
      end
      REG_HF_CTRL: begin
        rd_mux[HF_TRIM_LO +: 10] = s_q.hf_trim;
        rd_mux[HF_START] = s_q.hf_cal_start;
      end
      REG_STAMP_CTRL: begin
        rd_mux[ST_ARM] = s_q.stamp_capture_arm;
        rd_mux[ST_PERSIST] = s_q.stamp_capture_persist;
        rd_mux[ST_INV] = s_q.stamp_edge_invert;
        rd_mux[ST_PIN_LO +: 2] = s_q.stamp_pin_select;
      end
      REG_STAMP_COUNT: rd_mux[STAMP_W-1:0] = s_q.stamp_interval_count; // see R13
      REG_SLOT_DELTA: rd_mux[SLOT_W-1:0] = s_q.cycles_to_next_slot;
      REG_HF_COUNT: rd_mux[HFCNT_W-1:0] = s_q.hf_cal_count;
      REG_STATUS: rd_mux[4:0] = {s_q.cal_state, s_q.hf_pwr, osc_on};
      REG_PIN_CFG: rd_mux[3:0] = s_q.pin_direction_config;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // next-state logic: time bases, stamp, calibration, then bus writes
  // (bus writes come last so a software set wins over a hardware clear)
  always_comb begin
    s_d = s_q;
    // lf time base
    s_d.lf_tick = 1'b0;
    case (s_q.clock_source_select)
      SRC_EXT_LF: s_d.lf_tick = alt_edge; // see R5
      SRC_EXT_ALL: begin
        if (alt_edge) begin
          if (s_q.ext_div >= ext_div_n - 10'd1) begin
            s_d.ext_div = 10'd0;
            s_d.lf_tick = 1'b1; // see R6
          end else begin
            s_d.ext_div = s_q.ext_div + 10'd1;
          end
        end
      end
      default: begin
        if (osc_on) begin
          if (s_q.osc_div >= osc_period - 10'd1) begin
            s_d.osc_div = 10'd0;
            s_d.lf_tick = 1'b1; // see R1
          end else begin
            s_d.osc_div = s_q.osc_div + 10'd1;
          end
        end else begin
          s_d.osc_div = 10'd0;
        end
      end
    endcase
    // hf time base: external edges or internal oscillator while powered
    s_d.hf_tick = ext_hf ? alt_edge : s_q.hf_pwr; // see R9
    s_d.hf_pwr = ~ext_hf & (WAKE_ACTIVE | SLOTS_ACTIVE
                 | (s_q.cal_state != CAL_IDLE && s_q.cal_state != CAL_DONE)); // see R8
    // time stamp; frozen while the calibration clock is gated
    if (s_q.calibration_clock_enable) begin // see R16
      if (s_q.lf_tick) begin
        s_d.live_cnt = s_q.live_cnt + 1'b1; // see R17
      end
      if (capture) begin
        s_d.stamp_interval_count = s_q.live_cnt; // see R13
        // a tick in the capture cycle opens the next interval, so none is lost
        s_d.live_cnt = STAMP_W'(s_q.lf_tick);
        s_d.cycles_to_next_slot = s_q.run_mode_select ? NEXT_SLOT_CYCLES : '0; // see R14
        if (!s_q.stamp_capture_persist) begin
          s_d.stamp_capture_arm = 1'b0; // see R12
        end
      end
      // hf calibration sequence
      case (s_q.cal_state)
        CAL_IDLE: begin
          if (s_q.hf_cal_start) begin
            s_d.cal_state = CAL_WARM; // see R18
            s_d.stab_cnt = '0;
          end
        end
        CAL_WARM: begin
          // external hf needs no settling time
          if (ext_hf || s_q.stab_cnt >= HF_STAB_CYC - 9'd1) begin
            s_d.cal_state = CAL_ALIGN;
          end else begin
            s_d.stab_cnt = s_q.stab_cnt + 9'd1;
          end
        end
        CAL_ALIGN: begin
          if (s_q.lf_tick) begin // see R21
            s_d.cal_state = CAL_COUNT;
            s_d.win_cnt = '0;
            s_d.hf_run_cnt = '0;
          end
        end
        CAL_COUNT: begin
          if (s_q.hf_tick) begin
            s_d.hf_run_cnt = s_q.hf_run_cnt + 1'b1;
          end
          if (s_q.lf_tick) begin
            s_d.win_cnt = s_q.win_cnt + 8'd1;
            if (s_q.win_cnt == win_target - 8'd1) begin
              // include the hf tick of the closing cycle in the window
              s_d.hf_cal_count = s_q.hf_run_cnt + HFCNT_W'(s_q.hf_tick); // see R19
              s_d.cal_state = CAL_DONE;
            end
          end
        end
        CAL_DONE: begin
          s_d.hf_cal_start = 1'b0; // see R19
          s_d.cal_state = CAL_IDLE; // see R20
        end
        default: s_d.cal_state = CAL_IDLE;
      endcase
    end
    // avalon slave: one wait cycle, read data latched at the release edge, write taken one edge later
    s_d.waitreq = 1'b1;
    if (bus_rd_phase) begin
      s_d.waitreq = 1'b0;
      s_d.rdata = rd_mux;
    end
    if (bus_wr) begin
      case (AVS_ADDRESS)
        REG_CLK_CTRL: begin
          {s_d.run_mode_select, s_d.calibration_clock_enable,
           s_d.alternate_clock_pin_select, s_d.clock_source_select,
           s_d.slow_lf_osc_enable, s_d.fast_lf_osc_enable, s_d.lf_rate_select} =
            {AVS_BYTEENABLE[2] ? AVS_WRITEDATA[CC_RUN] : s_q.run_mode_select,
             AVS_BYTEENABLE[1] ? AVS_WRITEDATA[CC_CAL_EN] : s_q.calibration_clock_enable,
             AVS_BYTEENABLE[1] ? AVS_WRITEDATA[CC_ALT_LO +: 2] : s_q.alternate_clock_pin_select,
             AVS_BYTEENABLE[0] ? AVS_WRITEDATA[CC_SRC_LO +: 2] : s_q.clock_source_select,
             AVS_BYTEENABLE[0] ? AVS_WRITEDATA[CC_SLOW_EN] : s_q.slow_lf_osc_enable,
             AVS_BYTEENABLE[0] ? AVS_WRITEDATA[CC_FAST_EN] : s_q.fast_lf_osc_enable,
             AVS_BYTEENABLE[0] ? AVS_WRITEDATA[CC_RATE] : s_q.lf_rate_select};
        end
        REG_LF_TRIM: begin
          s_d.slow_lf_trim = (s_q.slow_lf_trim & ~wmask[TR_SLOW_LO +: 6])
                           | (AVS_WRITEDATA[TR_SLOW_LO +: 6] & wmask[TR_SLOW_LO +: 6]);
          s_d.fast_lf_trim = (s_q.fast_lf_trim & ~wmask[TR_FAST_LO +: 10])
                           | (AVS_WRITEDATA[TR_FAST_LO +: 10] & wmask[TR_FAST_LO +: 10]);
        end
        REG_HF_CTRL: begin
          s_d.hf_trim = (s_q.hf_trim & ~wmask[HF_TRIM_LO +: 10])
                      | (AVS_WRITEDATA[HF_TRIM_LO +: 10] & wmask[HF_TRIM_LO +: 10]);
          if (AVS_BYTEENABLE[2]) begin
            s_d.hf_cal_start = AVS_WRITEDATA[HF_START];
          end
        end
        REG_STAMP_CTRL: begin
          if (AVS_BYTEENABLE[0]) begin
            s_d.stamp_capture_arm = AVS_WRITEDATA[ST_ARM]; // see R11
            s_d.stamp_capture_persist = AVS_WRITEDATA[ST_PERSIST];
            s_d.stamp_edge_invert = AVS_WRITEDATA[ST_INV];
            s_d.stamp_pin_select = AVS_WRITEDATA[ST_PIN_LO +: 2];
          end
        end
        REG_PIN_CFG: begin
          if (AVS_BYTEENABLE[0]) begin
            s_d.pin_direction_config = AVS_WRITEDATA[3:0];
          end
        end
        default: s_d.waitreq = 1'b1; // read-only or unmapped: ignored
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_q <= '0;
      s_q.waitreq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, all straight from state flops
  assign AVS_READDATA = s_q.rdata;
  assign AVS_WAITREQUEST = s_q.waitreq;
  assign LF_TICK = s_q.lf_tick;
  assign HF_TICK = s_q.hf_tick;
  assign FAST_LF_OSC_ON = s_q.fast_lf_osc_enable; // see R2
  assign SLOW_LF_OSC_ON = s_q.slow_lf_osc_enable;
  assign SLOW_LF_TRIM = s_q.slow_lf_trim;
  assign FAST_LF_TRIM = s_q.fast_lf_trim;
  assign HF_TRIM = s_q.hf_trim;
  assign HF_OSC_POWER = s_q.hf_pwr;
  assign PIN_INPUT_EN = s_q.pin_direction_config;
  assign RUN_MODE = s_q.run_mode_select;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  a_hf_ext_off: assert property (ext_hf |=> !s_q.hf_pwr) // see R8
    else $error("internal hf powered with external hf selected");
  a_lf_osc_gate: assert property ( // see R2
    (!s_q.clock_source_select[0] && !osc_on) |=> !s_q.lf_tick)
    else $error("lf tick from a disabled oscillator");
  a_arm_clear: assert property ( // see R12
    (capture && !s_q.stamp_capture_persist && !bus_wr) |=> !s_q.stamp_capture_arm)
    else $error("arm bit not cleared after capture");
  a_stamp_load: assert property ( // see R13
    capture |=> s_q.stamp_interval_count == $past(s_q.live_cnt)
    && s_q.live_cnt == STAMP_W'($past(s_q.lf_tick)))
    else $error("stamp count not loaded");
  a_cal_gated: assert property ( // see R16
    !s_q.calibration_clock_enable |=> s_q.live_cnt == $past(s_q.live_cnt))
    else $error("stamp counter moved while gated");
  a_ext_div_range: assert property ( // see R6
    (s_q.clock_source_select == SRC_EXT_ALL) |-> s_q.ext_div < ext_div_n)
    else $error("external divider out of range");
  a_cal_finish: assert property ( // see R19
    (s_q.calibration_clock_enable && s_q.cal_state == CAL_COUNT && s_q.lf_tick
     && s_q.win_cnt == win_target - 8'd1)
    |=> s_q.cal_state == CAL_DONE
    && s_q.hf_cal_count == $past(s_q.hf_run_cnt) + HFCNT_W'($past(s_q.hf_tick))
    ##1 s_q.cal_state == CAL_IDLE)
    else $error("calibration did not finish in order");
  a_cal_window: assert property ( // see R18
    s_q.cal_state == CAL_COUNT |-> s_q.win_cnt < win_target)
    else $error("calibration window overran");

  c_capture: cover property (capture ##1 s_q.stamp_capture_arm == 1'b0);
  c_cal_done: cover property (s_q.cal_state == CAL_DONE);
  c_ext_all_tick: cover property (s_q.clock_source_select == SRC_EXT_ALL && s_q.lf_tick);
endmodule

// File: test/oscts_ext_src.sv
// far-side model: external 32 MHz source, stamp trigger and two noisy pins.
// assumes the bench owns the trigger level and switches the source on.
`timescale 1ns/1ps

module oscts_ext_src (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic run, // external clock source active
  input wire logic trig, // time stamp trigger level
  output logic [3:0] gpio // pin levels
);
  logic [3:0] cnt_q;

  //////////////////////////////////////////////////////////////////////////////
  // free count; the clock never pauses while run is high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // clock on pin 0, trigger on pin 1 pins 2 and 3 toggle as noise
  assign gpio = {cnt_q[3], ~cnt_q[3], trig, run & cnt_q[1]};
endmodule

// File: test/tb_top.sv
// self-checking bench for clock select, stamp capture and hf calibration.
// assumes oscts_top answers each bus transfer after one wait cycle.
`timescale 1ns/1ps

module tb_top
  import oscts_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic wait_r, lf_tick, hf_tick, fast_on, slow_on, hf_pwr, run_mode;
  logic [5:0] slow_trim;
  logic [9:0] fast_trim, hf_trim;
  logic [3:0] gpio, pin_en;
  logic wake = 1'b0;
  logic slots = 1'b0;
  logic [15:0] nslot = 16'h1234;
  logic ext_run = 1'b0;
  logic trig = 1'b0;
  int miscompares = 0;
  int checks = 0;
  int p;

  oscts_top dut_u (.CLK(clk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_r), .GPIO_IN(gpio), .WAKE_ACTIVE(wake), .SLOTS_ACTIVE(slots),
    .NEXT_SLOT_CYCLES(nslot), .LF_TICK(lf_tick), .HF_TICK(hf_tick),
    .FAST_LF_OSC_ON(fast_on), .SLOW_LF_OSC_ON(slow_on), .SLOW_LF_TRIM(slow_trim),
    .FAST_LF_TRIM(fast_trim), .HF_TRIM(hf_trim), .HF_OSC_POWER(hf_pwr),
    .PIN_INPUT_EN(pin_en), .RUN_MODE(run_mode));
  oscts_ext_src src_u (.clk(clk), .rstn(rstn), .run(ext_run), .trig(trig), .gpio(gpio));

  // free-running system clock
  always #(CLK_NS / 2) clk = ~clk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one bus transfer; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    do @(posedge clk); while (wait_r !== 1'b0 && ++n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) chk("bus answer", 32'h1, 32'h0);
  endtask

  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    // let the written flops settle before any output is looked at
    @(posedge clk);
  endtask

  task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q & m);
  endtask

  // cycles between two lf ticks, bounded
  task automatic gap(output int pr);
    int n;
    n = 0;
    do @(posedge clk); while (lf_tick !== 1'b1 && ++n < 5000);
    pr = 1;
    do @(posedge clk); while (lf_tick !== 1'b1 && ++pr < 5000);
  endtask

  task automatic pulse_to(input logic v);
    trig <= v;
    repeat (10) @(posedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // reset values, read-only and unmapped places
  task automatic t_reset();
    rchk("clk ctrl", REG_CLK_CTRL, 32'hFFFFFFFF, 32'h0);
    chk("osc on", 32'h0, {fast_on, slow_on, hf_pwr});
    wreg(REG_HF_COUNT, 32'h0000FFFF);
    rchk("hf count", REG_HF_COUNT, 32'hFFFFFFFF, 32'h0);
    rchk("unmapped", 6'h3C, 32'hFFFFFFFF, 32'h0);
    wreg(REG_LF_TRIM, 32'h02000020);
    wreg(REG_HF_CTRL, 32'h00000155);
    chk("trims", {6'h20, 10'h200, 10'h155}, {slow_trim, fast_trim, hf_trim});
  endtask

  // internal oscillators and external sources
  task automatic t_clocks();
    wreg(REG_CLK_CTRL, 32'h3);
    chk("fast only", 32'h2, {fast_on, slow_on});
    gap(p);
    chk("fast period", 32'd25, p);
    wreg(REG_CLK_CTRL, 32'h4);
    chk("slow only", 32'h1, {fast_on, slow_on});
    gap(p);
    chk("slow period", 32'd781, p);
    wreg(REG_PIN_CFG, 32'h1);
    ext_run <= 1'b1;
    wreg(REG_CLK_CTRL, 32'h31);
    chk("pin input", 32'h1, pin_en);
    gap(p);
    chk("div 32", 32'd128, p);
    wreg(REG_CLK_CTRL, 32'h30);
    gap(p);
    chk("div 1000", 32'd4000, p);
    wreg(REG_CLK_CTRL, 32'h11);
    gap(p);
    chk("ext lf", 32'd4, p);
    ext_run <= 1'b0;
  endtask

  // stamp capture: gating, persist, interval, arm clear, slot delta, invert
  task automatic t_stamp();
    wreg(REG_CLK_CTRL, 32'h3);
    wreg(REG_PIN_CFG, 32'h2);
    wreg(REG_STAMP_CTRL, 32'h13);
    pulse_to(1'b1);
    pulse_to(1'b0);
    rchk("gated arm", REG_STAMP_CTRL, 32'h1, 32'h1);
    wreg(REG_CLK_CTRL, 32'h1003);
    pulse_to(1'b1);
    pulse_to(1'b0);
    repeat (480) @(posedge clk);
    pulse_to(1'b1);
    rchk("interval", REG_STAMP_COUNT, 32'hFFFFFF, 32'd20);
    rchk("persist", REG_STAMP_CTRL, 32'h1, 32'h1);
    pulse_to(1'b0);
    wreg(REG_CLK_CTRL, 32'h11003);
    wreg(REG_STAMP_CTRL, 32'h11);
    pulse_to(1'b1);
    rchk("arm clear", REG_STAMP_CTRL, 32'h1, 32'h0);
    rchk("slot delta", REG_SLOT_DELTA, 32'hFFFF, 32'h1234);
    pulse_to(1'b0);
    wreg(REG_STAMP_CTRL, 32'h15);
    pulse_to(1'b1);
    rchk("rise ignored", REG_STAMP_CTRL, 32'h1, 32'h1);
    pulse_to(1'b0);
    rchk("fall taken", REG_STAMP_CTRL, 32'h1, 32'h0);
    wreg(REG_CLK_CTRL, 32'h1003);
  endtask

  // hf calibration with a given lf base; slots decide the final power
  task automatic t_cal(input logic [31:0] ctrl, input logic [31:0] cnt, input logic sl);
    int n;
    n = 0;
    slots <= sl;
    wreg(REG_CLK_CTRL, ctrl);
    wreg(REG_HF_CTRL, 32'h00010155);
    repeat (2) @(posedge clk);
    chk("hf powered", 32'h1, hf_pwr);
    do rchk("", REG_HF_CTRL, 32'h0, 32'h0);
    while (dut_u.HF_TRIM === 10'h155 && hf_pwr_start_set() && ++n < 3000);
    checks = checks - n - 1;
    if (n >= 3000) chk("cal finish", 32'h1, 32'h0);
    rchk("hf count", REG_HF_COUNT, 32'hFFFF, cnt);
    chk("hf power after", {31'h0, sl}, hf_pwr);
    slots <= 1'b0;
  endtask

  function automatic logic hf_pwr_start_set();
    return rdata[HF_START] !== 1'b0;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // watchdog sized well past the longest expected run
  initial begin
    #(CLK_NS * 80000);
    miscompares++;
    complete_run();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_clocks();
    t_stamp();
    t_cal(32'h1003, 32'd3200, 1'b0);
    t_cal(32'h1004, 32'd3124, 1'b1);
    wake <= 1'b1;
    repeat (4) @(posedge clk);
    chk("wake power", 32'h1, hf_pwr);
    complete_run();
  end
endmodule
